// ### hdl/wake_source_config_regs.sv
/*
  Wake source configuration registers: internal wake control, external wake
  control and wake input pull control, with their decoded controls.
  Assumes the serial pins and all event inputs are synchronous to clk, and that
  restart, soft reset and fail-safe entry arrive as one-cycle pulses.
*/
// Function
// - Second timer wakes only when its bit set
// - First timer wakes only when its bit set
// - Reserved bits always read back zero
// - Stop watchdog disable bit, hardware may update
// - Restart clears only the stop watchdog disable bit, keeps all others
// - Global bit widens interrupt to all status
// - Measure mode disables wake inputs one, two
// - Measure mode runs measurement in Normal Mode
// - Low three bits enable wake inputs
// - Reset value enables all three wake inputs
// - Fail-safe entry forces wake register patterns
// - Pull field codes none, down, up, auto
// - Pull register resets to all zeros
// - Bus mode code 01 means wake capable
// - Writes take effect at chip select release
`timescale 1ns/1ps
module wake_source_config_regs
  import wake_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Serial register port
  input  wire logic       serial_chip_select_n,
  input  wire logic       serial_clk,
  input  wire logic       serial_data_in,
  output logic            serial_data_out,
  output logic            serial_data_out_en,
  // Device mode events
  input  wire logic       soft_reset_pulse,
  input  wire logic       restart_pulse,
  input  wire logic       failsafe_entry_pulse,
  input  wire logic       normal_mode,
  // Hardware update of the stop watchdog disable bit
  input  wire logic       wd_stop_hw_load,
  input  wire logic       wd_stop_hw_value,
  // Bus transceiver mode fields, from the bus control registers
  input  wire logic [1:0] can_mode,
  input  wire logic [1:0] lin1_mode,
  input  wire logic [1:0] lin2_mode,
  // Interrupt sources
  input  wire logic       wake_event,
  input  wire logic       status_event,
  output logic            int_request,
  // Wake source enables
  output logic            second_timer_wake_enable,
  output logic            first_timer_wake_enable,
  output logic [2:0]      input_wake_enable,
  output logic [2:0]      bus_wake_enable,
  output logic            bus_failsafe_restore,
  // Stop mode watchdog and measurement
  output logic            stop_watchdog_disable_hi,
  output logic            measure_active,
  // Wake input pull control, bit n for wake input n+1
  output logic [2:0]      pull_up_enable,
  output logic [2:0]      pull_down_enable,
  output logic [2:0]      pull_auto_enable
);

  //////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic is_wake_capable(input logic [1:0] mode);
    is_wake_capable = (mode == BUS_MODE_WAKE);
  endfunction

  // Stored bits outside the writable mask are never kept
  function automatic logic [7:0] merge_write(input logic [7:0] old_val,
                                             input logic [7:0] wr_val,
                                             input logic [7:0] mask);
    merge_write = (wr_val & mask) | (old_val & ~mask & 8'h00);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Serial port

  logic [6:0] frame_addr;
  logic [7:0] frame_data;
  logic       frame_write;
  logic [7:0] read_data;

  serial_frame_port u_port (
    .clk                  (clk),
    .rst                  (rst),
    .serial_chip_select_n (serial_chip_select_n),
    .serial_clk           (serial_clk),
    .serial_data_in       (serial_data_in),
    .serial_data_out      (serial_data_out),
    .serial_data_out_en   (serial_data_out_en),
    .frame_addr           (frame_addr),
    .frame_data           (frame_data),
    .frame_write          (frame_write),
    .read_data            (read_data)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [7:0] int_wake_r, int_wake_nxt;
  logic [7:0] ext_wake_r, ext_wake_nxt;
  logic [7:0] pull_ctrl_r, pull_ctrl_nxt;
  logic       bus_fs_r, bus_fs_nxt;

  // Priority: soft reset, fail-safe entry, restart, then serial write.
  // The hardware update of the watchdog bit is applied last so that it wins
  // over a serial write landing in the same cycle.
  always_comb begin
    int_wake_nxt  = int_wake_r;
    ext_wake_nxt  = ext_wake_r;
    pull_ctrl_nxt = pull_ctrl_r;
    bus_fs_nxt    = 1'b0;
    if (soft_reset_pulse) begin
      int_wake_nxt  = INT_RST_VAL;
      ext_wake_nxt  = EXT_RST_VAL;
      pull_ctrl_nxt = PULL_RST_VAL;
    end else if (failsafe_entry_pulse) begin
      ext_wake_nxt = (ext_wake_r & EXT_FS_KEEP) | EXT_FS_VAL;
      bus_fs_nxt   = 1'b1;
    end else if (restart_pulse) begin
      int_wake_nxt  = int_wake_r & INT_RESTART_KEEP;
      ext_wake_nxt  = ext_wake_r & EXT_RESTART_KEEP;
      pull_ctrl_nxt = pull_ctrl_r & PULL_RESTART_KEEP;
    end else if (frame_write) begin
      case (frame_addr)
        ADDR_INT_WAKE: begin
          int_wake_nxt = merge_write(int_wake_r, frame_data, INT_WR_MASK);
        end
        ADDR_EXT_WAKE: begin
          ext_wake_nxt = merge_write(ext_wake_r, frame_data, EXT_WR_MASK);
        end
        ADDR_PULL_CTRL: begin
          pull_ctrl_nxt = merge_write(pull_ctrl_r, frame_data, PULL_WR_MASK);
        end
        default: begin
          int_wake_nxt = int_wake_r;
        end
      endcase
    end
    if (wd_stop_hw_load && !soft_reset_pulse) begin
      int_wake_nxt[INT_WDSTOP_BIT] = wd_stop_hw_value;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      int_wake_r  <= INT_RST_VAL;
      ext_wake_r  <= EXT_RST_VAL;
      pull_ctrl_r <= PULL_RST_VAL;
      bus_fs_r    <= 1'b0;
    end else begin
      int_wake_r  <= int_wake_nxt;
      ext_wake_r  <= ext_wake_nxt;
      pull_ctrl_r <= pull_ctrl_nxt;
      bus_fs_r    <= bus_fs_nxt;
    end
  end

  // Stored reserved bits are always zero, and reads mask them with the writable mask too
  always_comb begin
    case (frame_addr)
      ADDR_INT_WAKE:  read_data = int_wake_r & INT_WR_MASK;
      ADDR_EXT_WAKE:  read_data = ext_wake_r & EXT_WR_MASK;
      ADDR_PULL_CTRL: read_data = pull_ctrl_r & PULL_WR_MASK;
      default:        read_data = 8'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Decoded controls

  logic [2:0] in_wake_raw;
  logic [2:0] in_wake_gated;
  logic [2:0] bus_wake_raw;
  logic [2:0] pu_raw;
  logic [2:0] pd_raw;
  logic [2:0] pa_raw;
  logic       ctl_out_r, ctl_out_nxt;
  logic [7:0] ctl_vec_r, ctl_vec_nxt;
  logic [2:0] in_wake_r;
  logic [2:0] bus_wake_r;
  logic [8:0] pull_r;
  logic [14:0] dec_nxt;
  logic [14:0] dec_r;

  assign in_wake_raw = {ext_wake_r[EXT_IN3_BIT], ext_wake_r[EXT_IN2_BIT], ext_wake_r[EXT_IN1_BIT]};
  // Measurement mode takes inputs one and two away whatever their enables say
  assign in_wake_gated = in_wake_raw & {1'b1, {2{!ext_wake_r[EXT_MEAS_BIT]}}};

  assign bus_wake_raw = {is_wake_capable(lin2_mode), is_wake_capable(lin1_mode), is_wake_capable(can_mode)};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_pull
      logic [1:0] sel;
      assign sel        = pull_ctrl_r[gi*PULL_FIELD_W +: PULL_FIELD_W];
      assign pu_raw[gi] = (sel == PULL_UP);
      assign pd_raw[gi] = (sel == PULL_DOWN);
      assign pa_raw[gi] = (sel == PULL_AUTO);
    end
  endgenerate

  // Outputs are registered so they change one cycle after their register
  always_comb begin
    ctl_out_nxt = wake_event || (ext_wake_r[EXT_GLOBAL_BIT] && status_event);
    ctl_vec_nxt = 8'h00;
    ctl_vec_nxt[0] = int_wake_r[INT_TIMER2_BIT];
    ctl_vec_nxt[1] = int_wake_r[INT_TIMER1_BIT];
    ctl_vec_nxt[2] = int_wake_r[INT_WDSTOP_BIT];
    ctl_vec_nxt[3] = ext_wake_r[EXT_MEAS_BIT] && normal_mode;
    dec_nxt = {pa_raw, pd_raw, pu_raw, bus_wake_raw, in_wake_gated};
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_out_r <= 1'b0;
      ctl_vec_r <= 8'h00;
      dec_r     <= 15'h0000;
    end else begin
      ctl_out_r <= ctl_out_nxt;
      ctl_vec_r <= ctl_vec_nxt;
      dec_r     <= dec_nxt;
    end
  end

  assign in_wake_r  = dec_r[2:0];
  assign bus_wake_r = dec_r[5:3];
  assign pull_r     = dec_r[14:6];

  assign int_request              = ctl_out_r;
  assign second_timer_wake_enable = ctl_vec_r[0];
  assign first_timer_wake_enable  = ctl_vec_r[1];
  assign stop_watchdog_disable_hi = ctl_vec_r[2];
  assign measure_active           = ctl_vec_r[3];
  assign input_wake_enable        = in_wake_r;
  assign bus_wake_enable          = bus_wake_r;
  assign bus_failsafe_restore     = bus_fs_r;
  assign pull_up_enable           = pull_r[2:0];
  assign pull_down_enable         = pull_r[5:3];
  assign pull_auto_enable         = pull_r[8:6];

endmodule

// ### hdl/wake_cfg_pkg.sv
/*
  Constants for the wake source configuration registers: serial frame layout,
  register addresses, field positions, reset, restart and fail-safe values.
  Assumes nothing of its surroundings.
*/
package wake_cfg_pkg;

  // Serial frame: 16 bits, least significant first
  localparam int unsigned FRAME_BITS    = 16;
  localparam int unsigned FRAME_ADDR_LO = 0;
  localparam int unsigned FRAME_ADDR_W  = 7;
  localparam int unsigned FRAME_WR_BIT  = 7;
  localparam int unsigned FRAME_DATA_LO = 8;
  localparam logic [4:0]  FRAME_CNT_END = 5'h10;
  localparam logic [4:0]  FRAME_CNT_DAT = 5'h08;

  // Register addresses
  localparam logic [6:0] ADDR_INT_WAKE  = 7'h06;
  localparam logic [6:0] ADDR_EXT_WAKE  = 7'h07;
  localparam logic [6:0] ADDR_PULL_CTRL = 7'h08;

  // Internal wake source control fields
  localparam int unsigned INT_TIMER2_BIT = 7;
  localparam int unsigned INT_TIMER1_BIT = 6;
  localparam int unsigned INT_WDSTOP_BIT = 2;

  // External wake source control fields
  localparam int unsigned EXT_GLOBAL_BIT = 7;
  localparam int unsigned EXT_MEAS_BIT   = 5;
  localparam int unsigned EXT_IN3_BIT    = 2;
  localparam int unsigned EXT_IN2_BIT    = 1;
  localparam int unsigned EXT_IN1_BIT    = 0;

  // Pull control: two bits per wake input, input n at bits 2n-1:2n-2
  localparam int unsigned PULL_FIELD_W = 2;
  localparam int unsigned NUM_INPUTS   = 3;

  // Writable bits of each register; every other bit reads zero
  localparam logic [7:0] INT_WR_MASK  = 8'hc4;
  localparam logic [7:0] EXT_WR_MASK  = 8'ha7;
  localparam logic [7:0] PULL_WR_MASK = 8'h3f;

  // Power-on and soft reset values
  localparam logic [7:0] INT_RST_VAL  = 8'h00;
  localparam logic [7:0] EXT_RST_VAL  = 8'h07;
  localparam logic [7:0] PULL_RST_VAL = 8'h00;

  // Restart: bits in the keep mask survive, the rest clear
  localparam logic [7:0] INT_RESTART_KEEP  = 8'hc0;
  localparam logic [7:0] EXT_RESTART_KEEP  = 8'ha7;
  localparam logic [7:0] PULL_RESTART_KEEP = 8'h3f;

  // Fail-safe entry: keep mask and forced value
  localparam logic [7:0] EXT_FS_KEEP  = 8'ha0;
  localparam logic [7:0] EXT_FS_VAL   = 8'h07;
  localparam logic [7:0] BUS1_FS_KEEP = 8'he0;
  localparam logic [7:0] BUS1_FS_VAL  = 8'h09;
  localparam logic [7:0] BUS2_FS_KEEP = 8'h00;
  localparam logic [7:0] BUS2_FS_VAL  = 8'h01;

  // Bus transceiver mode codes
  typedef enum logic [1:0] {
    BUS_MODE_OFF     = 2'h0,
    BUS_MODE_WAKE    = 2'h1,
    BUS_MODE_RX_ONLY = 2'h2,
    BUS_MODE_NORMAL  = 2'h3
  } bus_mode_e;

  // Wake input pull selection codes
  typedef enum logic [1:0] {
    PULL_NONE = 2'h0,
    PULL_DOWN = 2'h1,
    PULL_UP   = 2'h2,
    PULL_AUTO = 2'h3
  } pull_sel_e;

endpackage

// ### hdl/serial_frame_port.sv
/*
  Serial register port: 16-bit frames, chip select active low, data taken on
  the rising serial clock and given on the falling one, least significant first.
  Assumes serial pins synchronous to clk and a serial clock well below clk/4.
*/
`timescale 1ns/1ps
module serial_frame_port
  import wake_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Serial pins
  input  wire logic       serial_chip_select_n,
  input  wire logic       serial_clk,
  input  wire logic       serial_data_in,
  output logic            serial_data_out,
  output logic            serial_data_out_en,
  // Register side
  output logic [6:0]      frame_addr,
  output logic [7:0]      frame_data,
  output logic            frame_write,
  input  wire logic [7:0] read_data
);

  logic [15:0] shift_r, shift_nxt;
  logic [4:0]  cnt_r, cnt_nxt;
  logic        sclk_r, sclk_nxt;
  logic        cs_n_r, cs_n_nxt;
  logic        dout_r, dout_nxt;
  logic        wr_r, wr_nxt;

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    shift_nxt = shift_r;
    cnt_nxt   = cnt_r;
    dout_nxt  = dout_r;
    wr_nxt    = 1'b0;
    sclk_nxt  = serial_clk;
    cs_n_nxt  = serial_chip_select_n;
    if (cs_n_r && !serial_chip_select_n) begin
      cnt_nxt  = 5'h00;
      dout_nxt = 1'b0;
    end else if (!serial_chip_select_n) begin
      if (!sclk_r && serial_clk && cnt_r < FRAME_CNT_END) begin
        shift_nxt[cnt_r[3:0]] = serial_data_in;
        cnt_nxt               = cnt_r + 5'h01;
      end else if (sclk_r && !serial_clk) begin
        // Read bits follow once the address and write bit are complete
        dout_nxt = (cnt_r >= FRAME_CNT_DAT && cnt_r < FRAME_CNT_END) ? read_data[cnt_r[2:0]] : 1'b0;
      end
    end
    // Commit only on chip select release after a whole frame
    if (!cs_n_r && serial_chip_select_n && cnt_r == FRAME_CNT_END) begin
      wr_nxt = shift_r[FRAME_WR_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_r <= 16'h0000;
      cnt_r   <= 5'h00;
      sclk_r  <= 1'b0;
      cs_n_r  <= 1'b1;
      dout_r  <= 1'b0;
      wr_r    <= 1'b0;
    end else begin
      shift_r <= shift_nxt;
      cnt_r   <= cnt_nxt;
      sclk_r  <= sclk_nxt;
      cs_n_r  <= cs_n_nxt;
      dout_r  <= dout_nxt;
      wr_r    <= wr_nxt;
    end
  end

  assign frame_addr         = shift_r[FRAME_ADDR_LO +: FRAME_ADDR_W];
  assign frame_data         = shift_r[FRAME_DATA_LO +: 8];
  assign frame_write        = wr_r;
  assign serial_data_out    = dout_r;
  assign serial_data_out_en = !cs_n_r;

endmodule

// ### testbench/wake_source_config_regs_props.sv
/*
  Checker for the wake source registers, bound to the top module.
  Assumes mode events never fall inside a serial frame.
*/
`timescale 1ns/1ps
module wake_source_config_regs_props (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Events and levels
  input wire logic       soft_reset_pulse,
  input wire logic       restart_pulse,
  input wire logic       failsafe_entry_pulse,
  input wire logic       wd_stop_hw_load,
  input wire logic       wd_stop_hw_value,
  input wire logic [1:0] can_mode,
  input wire logic [1:0] lin1_mode,
  input wire logic [1:0] lin2_mode,
  input wire logic       wake_event,
  input wire logic       status_event,
  // Decoded outputs
  input wire logic       int_request,
  input wire logic       second_timer_wake_enable,
  input wire logic       first_timer_wake_enable,
  input wire logic [2:0] input_wake_enable,
  input wire logic [2:0] bus_wake_enable,
  input wire logic       bus_failsafe_restore,
  input wire logic       stop_watchdog_disable_hi,
  input wire logic       measure_active,
  input wire logic [2:0] pull_up_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////
  property p_int_wake; wake_event |=> int_request; endproperty
  a_int_wake: assert property (p_int_wake) else $error("wake event gave no interrupt");
  property p_int_quiet; !wake_event && !status_event |=> !int_request; endproperty
  a_int_quiet: assert property (p_int_quiet) else $error("interrupt without cause");
  property p_meas; measure_active |-> input_wake_enable[1:0] == 2'h0; endproperty
  a_meas: assert property (p_meas) else $error("inputs one, two wake in measure mode");
  // Bus wake follows the mode code one clock later; skip the edge after reset
  property p_bus_mode; !$past(rst) |-> bus_wake_enable == {$past(lin2_mode) == 2'h1,
    $past(lin1_mode) == 2'h1, $past(can_mode) == 2'h1}; endproperty
  a_bus_mode: assert property (p_bus_mode) else $error("bus wake decode wrong");
  property p_failsafe; failsafe_entry_pulse && !soft_reset_pulse |=> bus_failsafe_restore
    ##1 input_wake_enable[2]; endproperty
  a_failsafe: assert property (p_failsafe) else $error("fail-safe patterns missing");
  property p_soft; soft_reset_pulse |-> ##2 (input_wake_enable == 3'h7 && pull_up_enable == 3'h0
    && !second_timer_wake_enable && !stop_watchdog_disable_hi); endproperty
  a_soft: assert property (p_soft) else $error("soft reset values wrong");
  property p_restart; restart_pulse && !soft_reset_pulse && !failsafe_entry_pulse && !wd_stop_hw_load
    |-> ##2 (!stop_watchdog_disable_hi && $stable(first_timer_wake_enable)
    && $stable(second_timer_wake_enable)); endproperty
  a_restart: assert property (p_restart) else $error("restart values wrong");
  property p_wd_hw; wd_stop_hw_load && !soft_reset_pulse
    |-> ##2 stop_watchdog_disable_hi == $past(wd_stop_hw_value, 2); endproperty
  a_wd_hw: assert property (p_wd_hw) else $error("hardware watchdog bit not taken");

  c_failsafe: cover property (bus_failsafe_restore);
  c_meas: cover property (measure_active);
  c_restart: cover property (restart_pulse);
endmodule

bind wake_source_config_regs wake_source_config_regs_props chk (.*);

// ### testbench/serial_host_model.sv
/*
  Host controller model running 16-bit serial frames, mode 0, lsb first.
  Assumes the bench starts one frame at a time through xfer.
*/
`timescale 1ns/1ps
module serial_host_model (
  // Clock
  input wire logic clk,
  // Serial pins
  output logic     serial_chip_select_n,
  output logic     serial_clk,
  output logic     serial_data_in,
  input wire logic serial_data_out
);
  initial begin
    serial_chip_select_n = 1'b1;
    serial_clk = 1'b0;
    serial_data_in = 1'b0;
  end

  // Data line is not held between frames, so a stale bit never looks valid
  always @(posedge clk) begin
    if (serial_chip_select_n) begin
      serial_data_in <= ~serial_data_in;
    end
  end

  ////////////////////////////////////////////////////////////
  // Serial clock is high for four system clocks and low for five, above the three required
  task automatic xfer(input logic [6:0] ad, input logic w, input logic [7:0] dv, output logic [7:0] q);
    logic [15:0] f;
    f = {dv, w, ad};
    q = 8'h00;
    @(posedge clk);
    serial_chip_select_n <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      serial_data_in <= f[i];
      repeat (4) @(posedge clk);
      serial_clk <= 1'b1;
      // Only register data is taken back; no level status is used
      if (i >= 8) q[i-8] = serial_data_out;
      repeat (4) @(posedge clk);
      serial_clk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    serial_chip_select_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
endmodule

// ### testbench/wake_source_config_regs_tb.sv
/*
  Self-checking bench for the wake source registers, driven by the host model.
  Assumes a 125 MHz clock and one serial frame at a time.
*/
`timescale 1ns/1ps
module wake_source_config_regs_tb
  import wake_cfg_pkg::*;
;
  logic        clk = 1'b0, rst = 1'b1, normal_mode = 1'b0, wake_event = 1'b0, status_event = 1'b0;
  logic        soft_reset_pulse = 1'b0, restart_pulse = 1'b0, failsafe_entry_pulse = 1'b0;
  logic        wd_stop_hw_load = 1'b0, wd_stop_hw_value = 1'b0;
  logic [1:0]  can_mode = 2'h0, lin1_mode = 2'h0, lin2_mode = 2'h0;
  logic        serial_chip_select_n, serial_clk, serial_data_in, serial_data_out, serial_data_out_en;
  logic        int_request, second_timer_wake_enable, first_timer_wake_enable, bus_failsafe_restore;
  logic        stop_watchdog_disable_hi, measure_active;
  logic [2:0]  input_wake_enable, bus_wake_enable, pull_up_enable, pull_down_enable, pull_auto_enable;
  logic [18:0] outs, e, obs_val;
  logic [18:0] exp_q[$];
  logic [14:0] tbl[6] = '{15'h08e4, 15'h081b, 15'h07ff, 15'h06ff, 15'h0705, 15'h09ff};
  logic [31:0] seed = 32'h1f96, r;
  logic [6:0]  a;
  logic [7:0]  d, ri = 8'h00, re = 8'h07, rp = 8'h00;
  logic        obs_v = 1'b0, obs_kind = 1'b0;
  int          err_total = 0, num_checks = 0, cyc = 0;

  wake_source_config_regs uut (.*);
  serial_host_model host (.*);

  assign outs = {second_timer_wake_enable, first_timer_wake_enable, input_wake_enable, bus_wake_enable,
                 stop_watchdog_disable_hi, measure_active, pull_up_enable, pull_down_enable, pull_auto_enable};

  always #4 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [18:0] dec_exp();
    logic [2:0] u, dn, au;
    for (int n = 0; n < 3; n++) begin
      u[n] = rp[2*n+:2] == PULL_UP;
      dn[n] = rp[2*n+:2] == PULL_DOWN;
      au[n] = rp[2*n+:2] == PULL_AUTO;
    end
    return {ri[7], ri[6], re[2], re[1:0] & ~{2{re[5]}}, lin2_mode == BUS_MODE_WAKE,
            lin1_mode == BUS_MODE_WAKE, can_mode == BUS_MODE_WAKE, ri[2], re[5] & normal_mode, u, dn, au};
  endfunction

  ////////////////////////////////////////////////////////////
  task automatic tally(input string what, input logic [18:0] ev, input logic [18:0] gv);
    num_checks++;
    if (gv !== ev) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, ev, gv);
    end
  endtask

  task automatic compare_read(input logic [7:0] ev, input logic [7:0] gv);
    tally("read data", {11'h0, ev}, {11'h0, gv});
  endtask

  task automatic compare_outs(input logic [18:0] ev, input logic [18:0] gv);
    tally("decoded outputs", ev, gv);
  endtask

  task automatic post(input logic k, input logic [18:0] ev, input logic [18:0] gv);
    exp_q.push_back(ev);
    obs_kind <= k;
    obs_val <= gv;
    obs_v <= 1'b1;
    @(posedge clk);
    obs_v <= 1'b0;
  endtask

  task automatic wr(input logic [6:0] ad, input logic [7:0] dv);
    logic [7:0] q;
    host.xfer(ad, 1'b1, dv, q);
    if (ad == ADDR_INT_WAKE) ri = dv & 8'hc4;
    if (ad == ADDR_EXT_WAKE) re = dv & 8'ha7;
    if (ad == ADDR_PULL_CTRL) rp = dv & 8'h3f;
  endtask

  task automatic rd(input logic [6:0] ad, input logic [7:0] ev);
    logic [7:0] q;
    host.xfer(ad, 1'b0, 8'h00, q);
    post(1'b0, {11'h0, ev}, {11'h0, q});
  endtask

  task automatic chk_outs();
    repeat (3) @(posedge clk);
    post(1'b1, dec_exp(), outs);
  endtask

  // Order: soft reset, restart, fail-safe, hardware watchdog load
  task automatic pulse(input logic [3:0] which);
    {soft_reset_pulse, restart_pulse, failsafe_entry_pulse, wd_stop_hw_load} <= which;
    @(posedge clk);
    {soft_reset_pulse, restart_pulse, failsafe_entry_pulse, wd_stop_hw_load} <= 4'h0;
  endtask

  task automatic summarize();
    if (err_total == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (obs_v === 1'b1) begin
      e = exp_q.pop_front();
      if (obs_kind) compare_outs(e, obs_val);
      else compare_read(e[7:0], obs_val[7:0]);
    end
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    {wake_event, status_event} <= cyc[4:3] ^ cyc[7:6];
    if (cyc == 30000) begin
      err_total++;
      summarize();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    chk_outs();
    rd(ADDR_INT_WAKE, 8'h00);
    rd(ADDR_EXT_WAKE, 8'h07);
    rd(ADDR_PULL_CTRL, 8'h00);
    for (int i = 0; i < 18; i++) begin
      r = rnd();
      {normal_mode, can_mode, lin1_mode, lin2_mode} <= {r[22] | (i < 6), r[21:16]};
      {a, d} = (i < 6) ? tbl[i] : {7'h06 + 7'(r[1:0]), r[15:8]};
      wr(a, d);
      rd(a, a == 7'h06 ? ri : a == 7'h07 ? re : a == 7'h08 ? rp : 8'h00);
      chk_outs();
    end
    wr(ADDR_INT_WAKE, 8'hff);
    wr(ADDR_PULL_CTRL, 8'h2d);
    pulse(4'h4);
    ri = ri & 8'hc0;
    chk_outs();
    rd(ADDR_INT_WAKE, ri);
    rd(ADDR_PULL_CTRL, rp);
    wr(ADDR_EXT_WAKE, 8'hf8);
    pulse(4'h2);
    re = (re & 8'ha0) | 8'h07;
    chk_outs();
    rd(ADDR_EXT_WAKE, re);
    wd_stop_hw_value <= 1'b1;
    pulse(4'h1);
    ri[2] = 1'b1;
    chk_outs();
    rd(ADDR_INT_WAKE, ri);
    pulse(4'h8);
    {ri, re, rp} = {8'h00, 8'h07, 8'h00};
    chk_outs();
    rd(ADDR_EXT_WAKE, re);
    repeat (4) @(posedge clk);
    summarize();
  end
endmodule
